// file: rtl/audio_dynamics_processor.sv
// Main/sub compressors, shelf filter and 128x interpolation.
// Assumes one sample strobe per frame, at least 10 clocks apart.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "audio_dynamics_defs.svh"

// Functional notes
// - table top 142 is 0 dB, 110 -96 dB
// - table entries are signed 2.20 gains
// - delay signal, detector sees undelayed input
// - look-ahead in samples, up to 100
// - main detector uses (L+R)/2
// - five cascaded post gain multiplies
// - hold detector output for hold count
// - release steps of 0.137 dB/s
// - sub input is weighted L/R sum
// - biquad filters only sub detector input
// - sub compressor has no look-ahead
// - first-order shelf, 50us pole, 15us zero
// - three rate sets chosen by bits 5:4
// - aux pin forces 44.1 kHz curve
// - sub reinjected into mains, 2.20 gains
// - mains 128x interpolated, about 24 samples
// - sub output is not interpolated
// - 33 entries, 3 dB per index
// - upper bits index, lower bits interpolate
module audio_dynamics_processor
  import audio_dynamics_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [8:0] addr_i,
  input wire logic [21:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [21:0] rd_data_o,
  // Audio in
  input wire logic sample_stb_i,
  input wire smp_t left_i,
  input wire smp_t right_i,
  input wire logic os_tick_i,
  input wire logic deemphasis_aux_pin_i,
  // Audio out
  output smp_t left_o,
  output smp_t right_o,
  output smp_t sub_o
);

  ////////////////////////////////////////////////////////////////
  // Storage
  gain_t prm [0:255]; // Parameter RAM
  smp_t lbuf_l [0:127]; // Look-ahead line
  smp_t lbuf_r [0:127];
  smp_t ibuf_l [0:31]; // Interpolator delay line
  smp_t ibuf_r [0:31];
  dp_t dp_ff, nx; // Datapath state
  logic [5:0] ctrl_ff, nxt_ctrl; // Control register 1
  logic [21:0] nxt_rd;
  logic [2:0] sy_ff; // Pin synchroniser
  logic pin_ff, nxt_pin; // Agreed pin level
  // Combinational temporaries
  smp_t mid, sin, bqy, rl, rr, shl, shr, dql, dqr;
  logic [25:0] cur;
  gain_t g0, g1;
  logic [1:0] sel;
  logic [6:0] la;
  logic [21:0] rel, la_raw, tcw;

  // Parameters read as plain words
  assign rel = prm[`ADP_REL_ADDR];
  assign tcw = prm[`ADP_TC_ADDR];
  assign la_raw = prm[`ADP_LA_ADDR];
  assign la = (la_raw > 22'(`ADP_LA_MAX)) ? `ADP_LA_MAX : la_raw[6:0];
  assign sel = pin_ff ? `ADP_SHELF_441 : ctrl_ff[`ADP_SHELF_HI:`ADP_SHELF_LO];

  // Outputs straight from flip-flops
  assign left_o = dp_ff.al[30:7];
  assign right_o = dp_ff.ar[30:7];
  assign sub_o = dp_ff.so;

  ////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  // Product by a 2.20 word, unsaturated
  function automatic logic signed [47:0] mulr(input smp_t a, input gain_t g);
    mulr = (48'(a) * 48'(g)) >>> 20;
  endfunction

  function automatic smp_t sat24(input logic signed [47:0] v);
    if (v > 48'sh7fffff) begin
      sat24 = 24'sh7fffff;
    end else if (v < -48'sh800000) begin
      sat24 = -24'sh800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // Saturating 2.20 multiply
  function automatic smp_t mulg(input smp_t a, input gain_t g);
    mulg = sat24(mulr(a, g));
  endfunction

  // Mean-square smoother; top 16 bits keep the square in 31 bits
  function automatic logic [31:0] rms(input logic [31:0] m, input smp_t x, input gain_t tc);
    logic signed [15:0] h;
    logic signed [63:0] d;
    h = x[23:8];
    d = 64'(32'(h) * 32'(h)) - $signed({32'h0, m});
    d = (d * 64'(tc)) >>> 20;
    rms = 32'($signed({32'h0, m}) + d);
  endfunction

  // one index step per power octave (3 dB)
  function automatic logic [25:0] lg(input logic [31:0] m);
    logic [5:0] e;
    logic [3:0] f;
    e = '0;
    f = '0;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) begin
        e = 6'(i);
        f = 4'({m, 4'h0} >> i);
      end
    end
    // full-scale square lands on the top entry
    e = (e + `ADP_IDX_OFS > `ADP_TBL_TOP) ? `ADP_TBL_TOP : e + `ADP_IDX_OFS;
    if (e == `ADP_TBL_TOP) begin
      f = '0;
    end
    lg = (m == '0) ? '0 : {e, f, 16'h0};
  endfunction

  function automatic gain_t tgain(input logic [25:0] lv, input logic [7:0] base);
    logic [5:0] ix;
    logic signed [31:0] t0, t1;
    ix = lv[25:20];
    t0 = 32'(prm[8'(base + 8'(ix))]);
    t1 = (ix == `ADP_TBL_TOP) ? t0 : 32'(prm[8'(base + 8'(ix) + 8'h1)]);
    tgain = gain_t'(t0 + (((t1 - t0) * 32'($signed({1'b0, lv[19:12]}))) >>> 8));
  endfunction

  // shelf coefficients b0, b1, a1 per rate
  function automatic gain_t shc(input logic [1:0] s, input logic [1:0] j);
    case ({s, j})
      4'h4: shc = 22'sh06bb2a;
      4'h5: shc = 22'sh3ec945;
      4'h6: shc = 22'sh358465;
      4'h8: shc = 22'sh06deca;
      4'h9: shc = 22'sh3f0b74;
      4'ha: shc = 22'sh35ea3c;
      4'hc: shc = 22'sh077778;
      4'hd: shc = 22'sh002702;
      4'he: shc = 22'sh379e7a;
      default: shc = '0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // Register port; read data valid only the cycle after a read
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rd = '0;
    if (wr_en_i && addr_i == `ADP_CTRL1_ADDR) begin
      nxt_ctrl = wr_data_i[5:0];
    end
    if (rd_en_i) begin
      if (!addr_i[8]) begin
        nxt_rd = prm[addr_i[7:0]];
      end else if (addr_i == `ADP_CTRL1_ADDR) begin
        nxt_rd = {16'h0, ctrl_ff};
      end else if (addr_i == `ADP_STAT_ADDR) begin
        nxt_rd = {9'h0, pin_ff, dp_ff.hl[1][25:20], dp_ff.hl[0][25:20]};
      end
    end
  end

  // Pin change counts once the last two stages agree
  always_comb begin
    nxt_pin = (sy_ff[1] == sy_ff[2]) ? sy_ff[2] : pin_ff;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff <= '0;
      rd_data_o <= '0;
      sy_ff <= '0;
      pin_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rd_data_o <= nxt_rd;
      sy_ff <= {sy_ff[1:0], deemphasis_aux_pin_i};
      pin_ff <= nxt_pin;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sample sequencer: detect, gain, five post stages, output
  always_comb begin
    nx = dp_ff;
    {mid, sin, bqy, rl, rr, shl, shr} = '0;
    cur = '0;
    g0 = '0;
    g1 = '0;
    dql = ibuf_l[5'(dp_ff.iw - `ADP_INTERP_DLY)];
    dqr = ibuf_r[5'(dp_ff.iw - `ADP_INTERP_DLY)];
    // ramp one step per oversample tick
    if (os_tick_i) begin
      nx.al = dp_ff.al + dp_ff.sl;
      nx.ar = dp_ff.ar + dp_ff.sr;
    end
    case (dp_ff.st)
      ST_IDLE: begin
        if (sample_stb_i) begin
          nx.il = left_i;
          nx.ir = right_i;
          nx.st = ST_DET;
        end
      end
      ST_DET: begin
        // mid signal feeds the main detector
        mid = smp_t'((25'(dp_ff.il) + 25'(dp_ff.ir)) >>> 1);
        // weighted sum into the sub path
        sin = sat24(mulr(dp_ff.il, prm[`ADP_WL_ADDR]) + mulr(dp_ff.ir, prm[`ADP_WR_ADDR]));
        // biquad in the sub detector only
        bqy = sat24(mulr(sin, prm[`ADP_BQ_B0]) + mulr(dp_ff.bx1, prm[`ADP_BQ_B1])
          + mulr(dp_ff.bx2, prm[`ADP_BQ_B2]) - mulr(dp_ff.by1, prm[`ADP_BQ_A1])
          - mulr(dp_ff.by2, prm[`ADP_BQ_A2]));
        nx.bx2 = dp_ff.bx1;
        nx.bx1 = sin;
        nx.by2 = dp_ff.by1;
        nx.by1 = bqy;
        nx.sb = sin;
        nx.ms[0] = rms(dp_ff.ms[0], mid, tcw);
        nx.ms[1] = rms(dp_ff.ms[1], bqy, tcw);
        for (int k = 0; k < 2; k++) begin
          cur = lg(nx.ms[k]);
          if (cur >= dp_ff.hl[k]) begin
            nx.hl[k] = cur;
            nx.hc[k] = prm[`ADP_HOLD_ADDR][15:0];
          end else if (dp_ff.hc[k] != '0) begin
            nx.hc[k] = dp_ff.hc[k] - 16'h1;
          end else if (27'(dp_ff.hl[k]) > 27'(cur) + 27'(rel)) begin
            nx.hl[k] = dp_ff.hl[k] - 26'(rel);
          end else begin
            nx.hl[k] = cur;
          end
        end
        // delayed copy goes to the multiplier
        nx.dl = (la == '0) ? dp_ff.il : lbuf_l[7'(dp_ff.lw - la)];
        nx.dr = (la == '0) ? dp_ff.ir : lbuf_r[7'(dp_ff.lw - la)];
        nx.lw = dp_ff.lw + 7'h1;
        nx.st = ST_GAIN;
      end
      ST_GAIN: begin
        g0 = tgain(dp_ff.hl[0], `ADP_MAIN_TBL);
        g1 = tgain(dp_ff.hl[1], `ADP_SUB_TBL);
        nx.pl = mulg(dp_ff.dl, g0);
        nx.pr = mulg(dp_ff.dr, g0);
        nx.sb = mulg(dp_ff.sb, g1);
        nx.pc = '0;
        nx.st = ST_POST;
      end
      ST_POST: begin
        nx.pl = mulg(dp_ff.pl, prm[`ADP_POST_ADDR]);
        nx.pr = mulg(dp_ff.pr, prm[`ADP_POST_ADDR]);
        nx.pc = dp_ff.pc + 3'h1;
        if (dp_ff.pc == `ADP_POST_LAST) begin
          nx.st = ST_OUT;
        end
      end
      ST_OUT: begin
        rl = sat24(48'(dp_ff.pl) + mulr(dp_ff.sb, prm[`ADP_RJ_L]));
        rr = sat24(48'(dp_ff.pr) + mulr(dp_ff.sb, prm[`ADP_RJ_R]));
        // rate set from field or pin
        shl = (sel == '0) ? rl : sat24(mulr(rl, shc(sel, 2'h0))
          + mulr(dp_ff.xl, shc(sel, 2'h1)) - mulr(dp_ff.yl, shc(sel, 2'h2)));
        shr = (sel == '0) ? rr : sat24(mulr(rr, shc(sel, 2'h0))
          + mulr(dp_ff.xr, shc(sel, 2'h1)) - mulr(dp_ff.yr, shc(sel, 2'h2)));
        nx.xl = rl;
        nx.xr = rr;
        nx.yl = shl;
        nx.yr = shr;
        nx.al = 32'(dp_ff.tl) <<< `ADP_INTERP_SH;
        nx.ar = 32'(dp_ff.tr) <<< `ADP_INTERP_SH;
        nx.sl = 32'(dql) - 32'(dp_ff.tl);
        nx.sr = 32'(dqr) - 32'(dp_ff.tr);
        nx.tl = dql;
        nx.tr = dqr;
        // sub goes out once per sample
        nx.so = dp_ff.sb;
        nx.iw = dp_ff.iw + 5'h1;
        nx.st = ST_IDLE;
      end
      default: begin
        nx.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dp_ff <= '{st: ST_IDLE, default: '0};
    end else begin
      dp_ff <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Memories; cleared at reset so nothing reads unknown
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 256; i++) begin
        prm[i] <= '0;
      end
      for (int i = 0; i < 128; i++) begin
        lbuf_l[i] <= '0;
        lbuf_r[i] <= '0;
      end
      for (int i = 0; i < 32; i++) begin
        ibuf_l[i] <= '0;
        ibuf_r[i] <= '0;
      end
    end else begin
      if (wr_en_i && !addr_i[8]) begin
        prm[addr_i[7:0]] <= wr_data_i;
      end
      if (dp_ff.st == ST_DET) begin
        lbuf_l[dp_ff.lw] <= dp_ff.il;
        lbuf_r[dp_ff.lw] <= dp_ff.ir;
      end
      if (dp_ff.st == ST_OUT) begin
        ibuf_l[dp_ff.iw] <= shl;
        ibuf_r[dp_ff.iw] <= shr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_gain;
    dp_ff.st == ST_GAIN;
  endsequence
  sequence s_post5;
    (dp_ff.st == ST_POST) [*5] ##1 (dp_ff.st == ST_OUT);
  endsequence
  property p_post_five;
    s_gain |=> s_post5;
  endproperty
  a_post_five: assert property (p_post_five) else $error("post gain not five stages");

  property p_sat;
    (dp_ff.st == ST_POST && !dp_ff.pl[23] && !prm[`ADP_POST_ADDR][21]) |=> !dp_ff.pl[23];
  endproperty
  a_sat: assert property (p_sat) else $error("post gain wrapped");

  property p_la_zero;
    (dp_ff.st == ST_DET && la == '0) |=> dp_ff.dl == $past(dp_ff.il);
  endproperty
  a_la_zero: assert property (p_la_zero) else $error("zero look-ahead delayed");

  property p_la_max;
    la <= `ADP_LA_MAX;
  endproperty
  a_la_max: assert property (p_la_max) else $error("look-ahead above limit");

  property p_hold;
    (dp_ff.st == ST_DET && dp_ff.hc[0] != '0 && lg(rms(dp_ff.ms[0], mid, tcw)) < dp_ff.hl[0])
      |=> dp_ff.hl[0] == $past(dp_ff.hl[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved during hold");

  property p_rel;
    (dp_ff.st == ST_DET && dp_ff.hc[0] == '0 && rel != '0
      && lg(rms(dp_ff.ms[0], mid, tcw)) < dp_ff.hl[0]) |=> dp_ff.hl[0] < $past(dp_ff.hl[0]);
  endproperty
  a_rel: assert property (p_rel) else $error("no release after hold");

  property p_top;
    dp_ff.hl[0][25:20] <= `ADP_TBL_TOP;
  endproperty
  a_top: assert property (p_top) else $error("table index past top");

  property p_pin;
    (sy_ff[2] && sy_ff[1]) |=> sel == `ADP_SHELF_441;
  endproperty
  a_pin: assert property (p_pin) else $error("pin did not force 44.1 curve");

  property p_sub_out;
    (dp_ff.st != ST_OUT) |=> $stable(sub_o);
  endproperty
  a_sub_out: assert property (p_sub_out) else $error("sub changed off sample");

  property p_interp;
    (!os_tick_i && dp_ff.st != ST_OUT) |=> $stable(left_o);
  endproperty
  a_interp: assert property (p_interp) else $error("left moved without tick");

endmodule

// file: rtl/audio_dynamics_defs.svh
// Offsets, field positions and constants of the dynamics block.
// Assumes 22-bit parameter words and 24-bit signed audio.
`ifndef AUDIO_DYNAMICS_DEFS_SVH
`define AUDIO_DYNAMICS_DEFS_SVH
`define ADP_CTRL1_ADDR 9'h100
`define ADP_STAT_ADDR 9'h101
`define ADP_MAIN_TBL 8'h6e
`define ADP_MAIN_TOP 8'h8e
`define ADP_SUB_TBL 8'ha0
`define ADP_LA_ADDR 8'h8f
`define ADP_HOLD_ADDR 8'h90
`define ADP_REL_ADDR 8'h91
`define ADP_TC_ADDR 8'h92
`define ADP_POST_ADDR 8'h93
`define ADP_WL_ADDR 8'h94
`define ADP_WR_ADDR 8'h95
`define ADP_BQ_B0 8'h96
`define ADP_BQ_B1 8'h97
`define ADP_BQ_B2 8'h98
`define ADP_BQ_A1 8'h99
`define ADP_BQ_A2 8'h9a
`define ADP_RJ_L 8'hc1
`define ADP_RJ_R 8'hc2
`define ADP_LA_MAX 7'h64
`define ADP_TBL_TOP 6'h20
`define ADP_IDX_OFS 6'h02
`define ADP_POST_LAST 3'h4
`define ADP_INTERP_SH 7
`define ADP_INTERP_DLY 5'h17
`define ADP_SHELF_HI 5
`define ADP_SHELF_LO 4
`define ADP_SHELF_441 2'h2
`endif

// file: rtl/audio_dynamics_pkg.sv
// Types shared by the dynamics block.
// Assumes the defs header supplies all numbers.
package audio_dynamics_pkg;
  typedef logic signed [23:0] smp_t;
  typedef logic signed [21:0] gain_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_DET = 5'h02, ST_GAIN = 5'h04, ST_POST = 5'h08, ST_OUT = 5'h10
  } state_t;
  typedef struct packed {
    state_t st;
    logic [2:0] pc;
    smp_t il, ir, dl, dr, sb, pl, pr, so;
    smp_t bx1, bx2, by1, by2;
    smp_t xl, xr, yl, yr, tl, tr;
    logic [1:0][31:0] ms;
    logic [1:0][25:0] hl;
    logic [1:0][15:0] hc;
    logic signed [31:0] al, ar, sl, sr;
    logic [6:0] lw;
    logic [4:0] iw;
  } dp_t;
endpackage

// file: bench/adp_host_model.sv
// Host side model: fills parameter RAM and the control word over the register port.
// Assumes the block never stalls the bus and the bench calls these tasks in sequence.
`include "audio_dynamics_defs.svh"

////////////////////////////////////////////////////////////
module adp_host_model (
  // Clock
  input wire logic clk_i,
  // Register port towards the block
  output logic [8:0] addr_o,
  output logic [21:0] wr_data_o,
  output logic wr_en_o,
  output logic rd_en_o,
  input wire logic [21:0] rd_data_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus from time zero
  initial begin
    addr_o = 9'h000;
    wr_data_o = 22'h000000;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
  end

  // One-cycle write; a gap edge follows so strobes never merge
  task automatic wr(input logic [8:0] a, input logic [21:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_en_o <= 1'b1;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
  endtask

  // One-cycle read; data taken just after the strobe edge
  task automatic rd(input logic [8:0] a, output logic [21:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    // Data stand only in the cycle after the strobe edge
    #1;
    d = rd_data_i;
  endtask

  // fifth root
  // Rounded, since pow may land one ulp short of an exact 2.20 word
  task automatic set_post_gain(input real lin);
    wr({1'b0, `ADP_POST_ADDR}, 22'($rtoi(lin ** 0.2 * 1048576.0 + 0.5)));
  endtask

  // rms coefficient
  // Rate must be negative dB per second
  task automatic set_tconst(input real rate, input real fs);
    wr({1'b0, `ADP_TC_ADDR}, 22'($rtoi((1.0 - 10.0 ** (rate / (10.0 * fs))) * 1048576.0 + 0.5)));
  endtask

  task automatic set_look_ahead(input int la, input int hold);
    wr({1'b0, `ADP_LA_ADDR}, 22'(la));
    wr({1'b0, `ADP_HOLD_ADDR}, 22'((hold < la) ? la : hold));
  endtask
endmodule

// file: bench/audio_dynamics_processor_tb_top.sv
// Self-checking bench for the dynamics block, host model on the register port.
// Assumes one frame per sample strobe and 128 tick pulses per frame.
`include "audio_dynamics_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t got %h exp %h", $time, a, b); end end

////////////////////////////////////////////////////////////
module audio_dynamics_processor_tb_top import audio_dynamics_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;

  // Stimulus and observed signals
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [8:0] addr;
  logic [21:0] wr_data, rd_data;
  logic wr_en, rd_en;
  logic stb = 1'b0;
  logic tick = 1'b0;
  logic aux_pin = 1'b0;
  smp_t left_in = '0;
  smp_t right_in = '0;
  smp_t left_out, right_out, sub_out;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  audio_dynamics_processor uut (
    .ref_clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wr_data_i(wr_data),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data), .sample_stb_i(stb),
    .left_i(left_in), .right_i(right_in), .os_tick_i(tick), .deemphasis_aux_pin_i(aux_pin),
    .left_o(left_out), .right_o(right_out), .sub_o(sub_out));

  adp_host_model host (
    .clk_i(clk), .addr_o(addr), .wr_data_o(wr_data), .wr_en_o(wr_en), .rd_en_o(rd_en),
    .rd_data_i(rd_data));

  ////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well above the ~55k cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      complete_run();
    end
  end

  // Reset clears parameter RAM and delay lines
  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask

  // Unity main table, unity post gain, unity sub entry at index zero
  task automatic base_cfg();
    for (int i = `ADP_MAIN_TBL; i <= `ADP_MAIN_TOP; i++) host.wr(9'(i), 22'h100000);
    host.set_post_gain(1.0);
    host.wr({1'b0, `ADP_SUB_TBL}, 22'h100000);
  endtask

  // One frame: strobe, sub sampled at its fixed latency, then a full ramp
  task automatic frame(input smp_t l, input smp_t r, output smp_t sub);
    @(posedge clk);
    stb <= 1'b1;
    left_in <= l;
    right_in <= r;
    @(posedge clk);
    stb <= 1'b0;
    repeat (9) @(posedge clk);
    #1 sub = sub_out;
    repeat (128) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1;
    `CHK(sub_out, sub)
  endtask

  ////////////////////////////////////////////////////////////
  // Reset values, read-back, read-only and unmapped places
  task automatic t_regs();
    logic [21:0] d;
    host.rd(`ADP_CTRL1_ADDR, d);
    `CHK(d, 22'h000000)
    host.wr(`ADP_CTRL1_ADDR, 22'h00003f);
    host.rd(`ADP_CTRL1_ADDR, d);
    `CHK(d, 22'h00003f)
    host.wr(9'h08e, 22'h2aaaaa);
    host.rd(9'h08e, d);
    `CHK(d, 22'h2aaaaa)
    host.wr(9'h12c, 22'h155555);
    host.rd(9'h12c, d);
    `CHK(d, 22'h000000)
    host.wr(`ADP_STAT_ADDR, 22'h3fffff);
    host.rd(`ADP_STAT_ADDR, d);
    `CHK(d, 22'h000000)
  endtask

  // Weighted sum, unfiltered sub path and clipping
  task automatic t_sub();
    smp_t s;
    do_reset();
    base_cfg();
    for (int i = `ADP_SUB_TBL; i <= 'hc0; i++) host.wr(9'(i), 22'h100000);
    host.set_look_ahead(50, 50);
    host.wr({1'b0, `ADP_WL_ADDR}, 22'h080000);
    host.wr({1'b0, `ADP_WR_ADDR}, 22'h040000);
    host.wr({1'b0, `ADP_BQ_B0}, 22'h080000);
    host.wr({1'b0, `ADP_BQ_B1}, 22'h100000);
    host.set_post_gain(3.0517578125);
    // Sub path carries no post gain and no biquad
    frame(24'h020000, 24'h040000, s);
    `CHK(s, 24'h020000)
    // Weights of 1.5 push the sum past full scale
    host.wr({1'b0, `ADP_WL_ADDR}, 22'h180000);
    host.wr({1'b0, `ADP_WR_ADDR}, 22'h180000);
    frame(24'h600000, 24'h600000, s);
    `CHK(s, 24'h7fffff)
    frame(24'ha00000, 24'ha00000, s);
    `CHK(s, 24'h800000)
  endtask

  // Detector sees (L+R)/2; full-scale square lands on the top entry
  task automatic t_det();
    logic [21:0] d;
    smp_t s;
    do_reset();
    base_cfg();
    host.set_tconst(-1.0e9, 48000.0);
    // Two-sample hold, one table index of release per sample
    host.wr({1'b0, `ADP_HOLD_ADDR}, 22'h000002);
    host.wr({1'b0, `ADP_REL_ADDR}, 22'h100000);
    repeat (4) frame(24'h7fffff, 24'h800001, s);
    host.rd(`ADP_STAT_ADDR, d);
    `CHK(d[5:0], 6'h00)
    repeat (4) begin
      frame(24'h7fffff, 24'h7fffff, s);
      frame(24'h800000, 24'h800000, s);
    end
    host.rd(`ADP_STAT_ADDR, d);
    `CHK(d[5:0], 6'h20)
    // Silence: level held two samples, then falls
    repeat (2) frame(24'h000000, 24'h000000, s);
    host.rd(`ADP_STAT_ADDR, d);
    `CHK(d[5:0], 6'h20)
    repeat (2) frame(24'h000000, 24'h000000, s);
    host.rd(`ADP_STAT_ADDR, d);
    `CHK(d[5:0], 6'h1e)
  endtask

  // Step through the delay line; edge must land 23+la frames later, and not one frame earlier when rj is clear
  task automatic t_step(input int la, input bit rj);
    smp_t s;
    do_reset();
    base_cfg();
    host.set_look_ahead(la, 0);
    if (rj) begin
      host.wr({1'b0, `ADP_WL_ADDR}, 22'h100000);
      host.wr({1'b0, `ADP_RJ_L}, 22'h100000);
    end else begin
      // Fifth power of 1.25 keeps every stage exact
      host.set_post_gain(3.0517578125);
    end
    for (int n = 0; n <= 23 + la; n++) begin
      frame(24'h123400, 24'hf54400, s);
      if (n == 22 + la && !rj) begin
        `CHK(left_out, 24'h000000)
        `CHK(right_out, 24'h000000)
      end
    end
    `CHK(left_out, rj ? 24'h246800 : 24'h378d31)
    `CHK(right_out, rj ? 24'hf54400 : 24'hdf3dc5)
    if (!rj) begin
      `CHK(right_out, 24'hdf3dc5)
    end
  endtask

  // Every shelf code plus the pin; Nyquist tone tells the curves apart
  task automatic t_shelf();
    smp_t res [5];
    logic [21:0] d;
    smp_t s;
    for (int k = 0; k < 5; k++) begin
      aux_pin <= (k == 4);
      do_reset();
      base_cfg();
      host.wr(`ADP_CTRL1_ADDR, {16'h0000, (k == 4) ? 2'h0 : 2'(k), 4'h0});
      for (int n = 0; n < 25; n++) frame(n[0] ? 24'hf00000 : 24'h100000, 24'h000000, s);
      res[k] = left_out;
    end
    host.rd(`ADP_STAT_ADDR, d);
    `CHK(d[12], 1'b1)
    aux_pin <= 1'b0;
    `CHK(res[0], 24'hf00000)
    `CHK(res[1] !== res[2], 1'b1)
    `CHK(res[2] !== res[3], 1'b1)
    `CHK(res[1] !== res[3], 1'b1)
    `CHK(res[4], res[2])
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset();
    t_regs();
    t_sub();
    t_det();
    t_step(0, 1'b1);
    t_step(7, 1'b0);
    t_shelf();
    complete_run();
  end
endmodule
